//--- rtl/wdp_watchdog.sv
// Watchdog timer with postscaler, status bits and interrupt
`include "wdp_regs.svh"

////////////////////////////////////////////////////////////////////////////
module wdp_watchdog
    import wdp_pkg::*;
#(
    parameter int BASE_TICKS = `WDP_BASE_TICKS,
    parameter int TIMER_TICKS = `WDP_TIMER_TICKS,
    parameter int PS_1 = `WDP_PS_1,
    parameter int PS_2 = `WDP_PS_2,
    parameter int PS_3 = `WDP_PS_3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Configuration and clocks
    input wire logic [1:0] postscale_select_cfg,
    input wire logic rc_tick,
    // CPU events
    input wire wdp_cpu_ev_t cpu_ev,
    input wire logic power_up_delay_timer,
    // Register port
    input wire wdp_bus_req_t bus,
    output logic [7:0] rdata,
    // Device effects
    output logic device_reset_req,
    output logic wake_req,
    output logic power_up_delay_timer_done,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    localparam int CW = 17;
    localparam int PW = 8;

    wdp_state_t state;
    wdp_state_t next_state;
    logic [CW-1:0] count;
    logic [PW-1:0] post;
    logic [PW-1:0] ps_limit;
    logic [7:0] cpu_status;
    logic [`WDP_IRQ_W-1:0] irq_stat;
    logic [`WDP_IRQ_W-1:0] irq_mask;
    logic [7:0] ctrl;
    logic timer_mode;
    logic enabled;
    logic sleeping;
    logic clr;
    logic step;
    logic base_end;
    logic expire;
    logic power_up_delay_timer_run;

    assign timer_mode = ctrl[`WDP_CTRL_TIMER];
    assign enabled = postscale_select_cfg != 2'h0;

    // Increasing ratios per code
    always_comb begin
        case (postscale_select_cfg)
            2'h1: ps_limit = PW'(PS_1 - 1);
            2'h2: ps_limit = PW'(PS_2 - 1);
            2'h3: ps_limit = PW'(PS_3 - 1);
            default: ps_limit = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencing
    always_comb begin
        next_state = state;
        case (state)
            WDP_ST_OFF: begin
                if (timer_mode)
                    next_state = WDP_ST_TIMER;
                else if (enabled || power_up_delay_timer_run)
                    next_state = WDP_ST_RUN;
            end
            WDP_ST_RUN: begin
                if (timer_mode && !power_up_delay_timer_run)
                    next_state = WDP_ST_TIMER;
                else if (cpu_ev.sleep_instr)
                    next_state = WDP_ST_SLEEP;
                else if (!enabled && !power_up_delay_timer_run)
                    next_state = WDP_ST_OFF;
            end
            WDP_ST_SLEEP: begin
                if (expire || cpu_ev.wake_by_irq)
                    next_state = WDP_ST_OFF;
            end
            WDP_ST_TIMER: begin
                if (!timer_mode)
                    next_state = WDP_ST_OFF;
            end
            default: next_state = WDP_ST_OFF;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            state <= WDP_ST_OFF;
        else
            state <= next_state;
    end

    assign sleeping = state == WDP_ST_SLEEP;
    // Timer mode sleep: wake_by_irq ends it; tracked with sleep flag below
    logic timer_asleep;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            timer_asleep <= 1'b0;
        else if (cpu_ev.wake_by_irq || state != WDP_ST_TIMER)
            timer_asleep <= 1'b0;
        else if (cpu_ev.sleep_instr)
            timer_asleep <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter and postscaler; software reaches them through the control timer bit and the clear and sleep instructions
    assign clr = cpu_ev.clear_watchdog_instr || cpu_ev.sleep_instr
        || cpu_ev.wake_by_irq;
    // RC tick in watchdog mode, every device clock in timer mode while not asleep
    assign step = (state == WDP_ST_TIMER) ? !timer_asleep
        : (rc_tick && state != WDP_ST_OFF);
    assign base_end = (state == WDP_ST_TIMER)
        ? count == CW'(TIMER_TICKS - 1)
        : count == CW'(BASE_TICKS - 1);
    assign expire = step && base_end && !clr
        && ((state == WDP_ST_TIMER) || post == ps_limit);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            post <= '0;
        end else if (clr || state == WDP_ST_OFF) begin
            count <= '0;
            post <= '0;
        end else if (step) begin
            if (base_end) begin
                count <= '0;
                post <= (post == ps_limit) ? '0 : post + 1'b1;
            end else begin
                count <= count + 1'b1;
            end
        end
    end

    // Power-up delay reuses the counter chain
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            power_up_delay_timer_run <= 1'b0;
        else if (power_up_delay_timer)
            power_up_delay_timer_run <= 1'b1;
        else if (expire)
            power_up_delay_timer_run <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            device_reset_req <= 1'b0;
            wake_req <= 1'b0;
            power_up_delay_timer_done <= 1'b0;
        end else begin
            device_reset_req <= expire && state == WDP_ST_RUN
                && enabled && !power_up_delay_timer_run;
            wake_req <= expire && sleeping;
            power_up_delay_timer_done <= expire && power_up_delay_timer_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // CPU status: expiry outside the power-up delay clears the flag and wins over a set
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cpu_status <= `WDP_CPU_STATUS_RST;
        end else begin
            if (expire && !power_up_delay_timer_run)
                cpu_status[`WDP_BIT_TO] <= 1'b0;
            else if (cpu_ev.clear_watchdog_instr || cpu_ev.sleep_instr)
                cpu_status[`WDP_BIT_TO] <= 1'b1;
            if (cpu_ev.sleep_instr)
                cpu_status[`WDP_BIT_PD] <= 1'b0;
            else if (cpu_ev.clear_watchdog_instr)
                cpu_status[`WDP_BIT_PD] <= 1'b1;
            if (bus.wr && bus.addr == `WDP_CPU_STATUS_OFS) begin
                cpu_status[`WDP_BIT_POR] <= bus.wdata[`WDP_BIT_POR];
                cpu_status[`WDP_BIT_BOR] <= bus.wdata[`WDP_BIT_BOR];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear, set wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_stat <= '0;
        end else begin
            for (int i = 0; i < `WDP_IRQ_W; i++) begin
                if (bus.wr && bus.addr == `WDP_IRQ_STAT_OFS
                    && bus.wdata[i])
                    irq_stat[i] <= 1'b0;
            end
            if (expire)
                irq_stat[`WDP_IRQ_EXPIRY] <= 1'b1;
            if (expire && sleeping)
                irq_stat[`WDP_IRQ_WAKE] <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            irq_mask <= '0;
        else if (bus.wr && bus.addr == `WDP_IRQ_MASK_OFS)
            irq_mask <= bus.wdata[`WDP_IRQ_W-1:0];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            ctrl <= `WDP_CTRL_RST;
        else if (bus.wr && bus.addr == `WDP_CTRL_OFS)
            ctrl <= {7'h00, bus.wdata[`WDP_CTRL_TIMER]};
    end

    assign irq = |(irq_stat & irq_mask);

    // Read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                `WDP_CPU_STATUS_OFS: rdata <= cpu_status;
                `WDP_IRQ_STAT_OFS: rdata <= {6'h00, irq_stat};
                `WDP_IRQ_MASK_OFS: rdata <= {6'h00, irq_mask};
                `WDP_CTRL_OFS: rdata <= {6'h00, power_up_delay_timer_run, timer_mode};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule

//--- rtl/wdp_regs.svh
// Offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDP_REGS_SVH
`define WDP_REGS_SVH
`define WDP_ADDR_W 8
`define WDP_DATA_W 8
`define WDP_CPU_STATUS_OFS 8'h06
`define WDP_IRQ_STAT_OFS 8'h40
`define WDP_IRQ_MASK_OFS 8'h41
`define WDP_CTRL_OFS 8'h42
// cpu_status fields
`define WDP_BIT_POR 0
`define WDP_BIT_BOR 1
`define WDP_BIT_PD 2
`define WDP_BIT_TO 3
`define WDP_CPU_STATUS_RST 8'h3F
// Interrupt status / mask fields
`define WDP_IRQ_EXPIRY 0
`define WDP_IRQ_WAKE 1
`define WDP_IRQ_W 2
// Control fields
`define WDP_CTRL_TIMER 0
`define WDP_CTRL_POWER_UP_DELAY_TIMER 1
`define WDP_CTRL_RST 8'h00
// Timing
`define WDP_NOMINAL_MS 12
`define WDP_LONGEST_MS 3000
`define WDP_RC_KHZ 64
`define WDP_BASE_TICKS ((`WDP_NOMINAL_MS * `WDP_RC_KHZ))
`define WDP_TIMER_TICKS 65536
// Postscale ratio per code; 00 means disabled
`define WDP_PS_1 1
`define WDP_PS_2 16
`define WDP_PS_3 250
`endif

//--- rtl/wdp_pkg.sv
// Types shared by the watchdog
package wdp_pkg;
    typedef enum logic [3:0] {
        WDP_ST_OFF = 4'h1,
        WDP_ST_RUN = 4'h2,
        WDP_ST_SLEEP = 4'h4,
        WDP_ST_TIMER = 4'h8
    } wdp_state_t;

    typedef struct packed {
        logic clear_watchdog_instr;
        logic sleep_instr;
        logic wake_by_irq;
    } wdp_cpu_ev_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdp_bus_req_t;
endpackage

//--- tb/wdp_watchdog_assertions.sv
// Port-level assertions for the watchdog with postscaler
module wdp_chk
    import wdp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Configuration and events
    input wire logic [1:0] postscale_select_cfg,
    input wire logic rc_tick,
    input wire wdp_cpu_ev_t cpu_ev,
    input wire logic power_up_delay_timer,
    input wire wdp_bus_req_t bus,
    // Design outputs
    input wire logic [7:0] rdata,
    input wire logic device_reset_req,
    input wire logic wake_req,
    input wire logic power_up_delay_timer_done,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Any clear keeps reset and wake requests low for the next three cycles
    sequence quiet_s;
        !device_reset_req && !wake_req;
    endsequence
    sequence quiet3_s;
        quiet_s [*3];
    endsequence

    clr_quiet_a: assert property (
        cpu_ev.clear_watchdog_instr |=> quiet3_s)
        else $error("expiry right after clear instruction");
    slp_quiet_a: assert property (
        cpu_ev.sleep_instr |=> quiet3_s)
        else $error("expiry right after sleep instruction");
    wake_quiet_a: assert property (
        cpu_ev.wake_by_irq |=> quiet3_s)
        else $error("expiry right after interrupt wake");
    rst_clean_a: assert property (
        $fell(rst) |-> quiet_s and (rdata == 8'h00 && !power_up_delay_timer_done))
        else $error("outputs active right after reset");
    rst_tick_a: assert property (
        device_reset_req |-> $past(rc_tick) &&
        $past(postscale_select_cfg) != 2'h0)
        else $error("device reset without tick or while disabled");
    wake_tick_a: assert property (
        wake_req |-> $past(rc_tick))
        else $error("wake request without oscillator tick");
    rst_pulse_a: assert property (
        device_reset_req |=> !device_reset_req)
        else $error("device reset request longer than one cycle");
    one_effect_a: assert property (
        !(device_reset_req && wake_req))
        else $error("reset and wake requested together");
    rdata_idle_a: assert property (
        !$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data without a read");
    power_up_delay_timer_start_a: assert property (
        power_up_delay_timer |=> !power_up_delay_timer_done)
        else $error("power-up delay ended at once");
endmodule

bind wdp_watchdog wdp_chk u_chk (.ref_clk, .rst, .postscale_select_cfg,
    .rc_tick, .cpu_ev, .power_up_delay_timer, .bus, .rdata,
    .device_reset_req, .wake_req, .power_up_delay_timer_done, .irq);

//--- tb/tb_top.sv
// Self-checking bench for the watchdog with postscaler
`include "wdp_regs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end

module tb_top
    import wdp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [1:0] cfg; int ticks;} wdp_row_t;
    // Short base count of 4 ticks, ratios shrunk to 1/2/3
    wdp_row_t rows[3] = '{'{2'h1, 4}, '{2'h2, 8}, '{2'h3, 12}};
    logic ref_clk = 0, rst = 1, rc_tick = 0, power_up_delay_timer = 0;
    logic [1:0] postscale_select_cfg = 2'h1;
    wdp_cpu_ev_t cpu_ev = '0;
    wdp_bus_req_t bus = '0;
    logic [7:0] rdata, d;
    logic device_reset_req, wake_req, power_up_delay_timer_done, irq, hit;
    int error_cnt = 0, cmp_count = 0, n;

    wdp_watchdog #(.BASE_TICKS(4), .TIMER_TICKS(16), .PS_2(2), .PS_3(3))
        uut (.ref_clk, .rst, .postscale_select_cfg, .rc_tick, .cpu_ev,
        .power_up_delay_timer, .bus, .rdata, .device_reset_req,
        .wake_req, .power_up_delay_timer_done, .irq);

    initial forever #2 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task results();
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task do_rst(input logic [1:0] c);
        @(posedge ref_clk) rst <= 1'b1;
        postscale_select_cfg <= c;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    // Ticks every other cycle; stops at the first reset or wake request
    task tick_run(input int lim);
        n = 0;
        hit = 0;
        while (n < lim && !hit) begin
            @(posedge ref_clk) rc_tick <= 1'b1;
            n++;
            @(posedge ref_clk) rc_tick <= 1'b0;
            @(negedge ref_clk) hit = device_reset_req | wake_req;
        end
    endtask

    task ev(input wdp_cpu_ev_t e);
        @(posedge ref_clk) cpu_ev <= e;
        @(posedge ref_clk) cpu_ev <= '0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk) bus <= '{a, v, 1'b1, 1'b0};
        @(posedge ref_clk) bus.wr <= 1'b0;
        @(negedge ref_clk);
    endtask

    task rd(input logic [7:0] a);
        @(posedge ref_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk) bus.rd <= 1'b0;
        @(negedge ref_clk) d = rdata;
    endtask

    initial begin
        #200000;
        error_cnt++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_rst(2'h1);
        rd(`WDP_CPU_STATUS_OFS);
        `CHK(d, `WDP_CPU_STATUS_RST)
        rd(8'h10);
        `CHK(d, 8'h00)
        foreach (rows[i]) begin
            do_rst(rows[i].cfg);
            tick_run(40);
            `CHK(n, rows[i].ticks)
            `CHK(device_reset_req, 1'b1)
            rd(`WDP_CPU_STATUS_OFS);
            `CHK(d[`WDP_BIT_TO], 1'b0)
        end
        rd(`WDP_IRQ_STAT_OFS);
        `CHK(d[`WDP_IRQ_EXPIRY], 1'b1)
        `CHK(irq, 1'b0)
        wr(`WDP_IRQ_MASK_OFS, 8'h01);
        `CHK(irq, 1'b1)
        wr(`WDP_IRQ_STAT_OFS, 8'h01);
        `CHK(irq, 1'b0)
        // A clear or wake midway restarts the full count
        do_rst(2'h1);
        tick_run(3);
        `CHK(hit, 1'b0)
        ev(3'b100);
        tick_run(20);
        `CHK(n, 4)
        ev(3'b010);
        tick_run(20);
        `CHK(n, 4)
        `CHK(wake_req, 1'b1)
        ev(3'b010);
        tick_run(2);
        ev(3'b001);
        tick_run(20);
        `CHK(n, 4)
        `CHK(device_reset_req, 1'b1)
        // Disabled code, then plain timer on the device clock
        do_rst(2'h0);
        @(posedge ref_clk) power_up_delay_timer <= 1'b1;
        @(posedge ref_clk) power_up_delay_timer <= 1'b0;
        tick_run(4);
        `CHK(power_up_delay_timer_done, 1'b1)
        tick_run(30);
        `CHK(hit, 1'b0)
        wr(`WDP_CTRL_OFS, 8'h01);
        // Overflow first, so the clear has a low flag to raise
        repeat (20) @(posedge ref_clk);
        rd(`WDP_CPU_STATUS_OFS);
        `CHK(d[`WDP_BIT_TO], 1'b0)
        ev(3'b100);
        rd(`WDP_CPU_STATUS_OFS);
        `CHK(d[`WDP_BIT_TO], 1'b1)
        ev(3'b010);
        repeat (30) @(posedge ref_clk);
        rd(`WDP_CPU_STATUS_OFS);
        `CHK(d[`WDP_BIT_TO], 1'b1)
        results();
    end
endmodule
